/* File: guard_pkg.sv */
// constants and types for the flash write-protection block
package guard_pkg;

    // ----------------------------------------
    // register map (word aligned byte offsets)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] STATUS_OFF  = 8'h04;
    localparam logic [7:0] CMD_OFF     = 8'h08;
    localparam logic [7:0] ADDR_OFF    = 8'h0c;
    localparam logic [7:0] RESULT_OFF  = 8'h10;
    localparam logic [7:0] RANGE_OFF   = 8'h14;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int GUARD_LSB    = 0;
    localparam int COMP_POS     = 5;
    localparam int LOCK_LSB     = 6;
    localparam int LATCH_POS    = 8;
    localparam int BUSY_POS     = 9;
    localparam int DEEP_POS     = 10;
    localparam int RECOV_POS    = 11;
    localparam int BITS_LSB     = 0;
    localparam int OP_LSB       = 8;

    // ----------------------------------------
    // reset values and geometry
    // ----------------------------------------
    localparam logic [7:0]  STATUS_RST  = 8'h00;
    localparam logic [7:0]  ARRAY_ERASED = 8'hff;
    localparam int          ADDR_W      = 19;
    localparam logic [18:0] ARRAY_LAST  = 19'h7ffff;
    localparam logic [18:0] PAGE_SPAN   = 19'h000ff;
    localparam logic [18:0] SECT_SPAN   = 19'h00fff;
    localparam logic [18:0] BLK32_SPAN  = 19'h07fff;
    localparam logic [18:0] BLK64_SPAN  = 19'h0ffff;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int RECOV4K_US    = 4500;
    localparam int RECOV64K_US   = 70000;
    localparam int RECOV4K_CYC   = RECOV4K_US * (CLK_HZ / 1_000_000);
    localparam int RECOV64K_CYC  = RECOV64K_US * (CLK_HZ / 1_000_000);
    localparam int OP_CYC        = 8;

    // ----------------------------------------
    // commands and engine states
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_UNLOCK   = 4'h1,
        OP_LOCK     = 4'h2,
        OP_WRSTAT   = 4'h3,
        OP_PROG     = 4'h4,
        OP_SECT     = 4'h5,
        OP_BLK32    = 4'h6,
        OP_BLK64    = 4'h7,
        OP_CHIP     = 4'h8,
        OP_SLEEP    = 4'h9,
        OP_WAKE     = 4'ha
    } op_t;

    typedef enum logic [3:0] {
        ST_STANDBY  = 4'b0001,
        ST_RECOVER  = 4'b0010,
        ST_BUSY     = 4'b0100,
        ST_DEEP     = 4'b1000
    } state_t;

endpackage

/* File: guard_if.sv */
// range carrier between the engine and the region decoder
`timescale 1ns/10ps
interface guard_if;
    logic [4:0]  bits;
    logic        comp;
    logic [18:0] lo;
    logic [18:0] hi;
    logic        any;
    modport dec (input bits, input comp, output lo, output hi, output any);
    modport eng (output bits, output comp, input lo, input hi, input any);
endinterface

/* File: guard_region.sv */
// decodes the guard field and complement bit into one protected range
`timescale 1ns/10ps
module guard_region (
    guard_if.dec g
);
    import guard_pkg::*;

    logic [18:0] lo;
    logic [18:0] hi;
    logic        any;
    logic [18:0] size;

    always_comb begin
        lo   = '0;
        hi   = '0;
        any  = 1'b0;
        size = '0;
        if (g.bits[2:0] == 3'b000) begin
            any = 1'b0;
        end else if (!g.bits[4] && g.bits[2]) begin
            any = 1'b1;
            hi  = ARRAY_LAST;
        end else if (g.bits[4] && g.bits[2:0] == 3'b111) begin
            any = 1'b1;
            hi  = ARRAY_LAST;
        end else begin
            any = 1'b1;
            if (!g.bits[4]) begin
                case (g.bits[1:0])
                    2'b01:   size = 19'h0ffff;
                    2'b10:   size = 19'h1ffff;
                    default: size = 19'h3ffff;
                endcase
            end else begin
                if (g.bits[2])
                    size = 19'h07fff;
                else if (g.bits[1:0] == 2'b01)
                    size = 19'h00fff;
                else if (g.bits[1:0] == 2'b10)
                    size = 19'h01fff;
                else
                    size = 19'h03fff;
            end
            if (g.bits[3]) begin
                lo = '0;
                hi = size;
            end else begin
                lo = ARRAY_LAST - size;
                hi = ARRAY_LAST;
            end
        end
        // complement of a one-sided range is the other side
        if (g.comp) begin
            if (!any) begin
                any = 1'b1;
                lo  = '0;
                hi  = ARRAY_LAST;
            end else if (lo == '0 && hi == ARRAY_LAST) begin
                any = 1'b0;
            end else if (lo == '0) begin
                lo = hi + 19'h1;
                hi = ARRAY_LAST;
            end else begin
                hi = lo - 19'h1;
                lo = '0;
            end
        end
    end

    assign g.lo  = lo;
    assign g.hi  = hi;
    assign g.any = any;

endmodule

/* File: flash_write_protection.sv */
// write-protection and power-up guard engine with an ahb-lite register slave
`timescale 1ns/10ps
module flash_write_protection (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        guard_pin_n,
    input  wire logic        erase_cut_4k,
    input  wire logic        erase_cut_64k,
    output logic             array_write,
    output logic      [18:0] write_lo,
    output logic      [18:0] write_hi,
    output logic             busy
);
    import guard_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        state_t      st;
        logic [4:0]  bits;
        logic        comp;
        logic [1:0]  lock;
        logic        latch;
        logic [18:0] addr;
        logic [3:0]  last_op;
        logic [1:0]  result;
        logic [31:0] cnt;
        logic        wr_ph;
        logic [7:0]  wr_off;
        logic [31:0] rdata;
        logic        awr;
        logic [18:0] lo_q;
        logic [18:0] hi_q;
        logic        strap;
        logic        busy_q;
    } regs_t;

    regs_t r_reg;
    regs_t r_next;

    guard_if g ();
    guard_region u_region (.g(g));

    assign g.bits = r_reg.bits;
    assign g.comp = r_reg.comp;

    logic        take;
    logic [18:0] span;
    logic [18:0] t_lo;
    logic [18:0] t_hi;
    logic        hit;
    logic [7:0]  status;
    logic [3:0]  opc;

    assign status = {r_reg.lock, r_reg.comp, r_reg.bits};
    assign take   = hsel && htrans[1] && hready;

    // ----------------------------------------
    // command decode and protection check
    // ----------------------------------------
    always_comb begin
        opc  = hwdata[OP_LSB +: 4];
        span = '0;
        case (opc)
            OP_PROG:  span = PAGE_SPAN;
            OP_SECT:  span = SECT_SPAN;
            OP_BLK32: span = BLK32_SPAN;
            OP_BLK64: span = BLK64_SPAN;
            default:  span = ARRAY_LAST;
        endcase
        // aligned granule that the command touches
        t_lo = r_reg.addr & ~span;
        t_hi = t_lo | span;
        if (opc == OP_CHIP) begin
            t_lo = '0;
            t_hi = ARRAY_LAST;
        end
        hit = g.any && !(t_hi < g.lo || t_lo > g.hi);
    end

    always_comb begin
        r_next     = r_reg;
        r_next.awr = 1'b0;
        if (r_reg.cnt != '0)
            r_next.cnt = r_reg.cnt - 32'h1;
        case (r_reg.st)
            ST_RECOVER: begin
                if (r_reg.strap) begin
                    r_next.strap = 1'b0;
                    if (erase_cut_64k)
                        r_next.cnt = 32'(RECOV64K_CYC);
                    else if (erase_cut_4k)
                        r_next.cnt = 32'(RECOV4K_CYC);
                    else
                        r_next.cnt = '0;
                end else if (r_reg.cnt == '0) begin
                    r_next.st = ST_STANDBY;
                end
            end
            ST_BUSY: begin
                if (r_reg.cnt == '0) begin
                    r_next.st    = ST_STANDBY;
                    r_next.latch = 1'b0;
                end
            end
            default: ;
        endcase

        // data phase of a write
        if (r_reg.wr_ph) begin
            r_next.wr_ph = 1'b0;
            if (r_reg.wr_off == ADDR_OFF) begin
                r_next.addr = hwdata[ADDR_W-1:0];
            end else if (r_reg.wr_off == CMD_OFF) begin
                r_next.last_op = opc;
                r_next.result  = 2'd1;
                if (r_reg.st == ST_DEEP) begin
                    if (opc == OP_WAKE)
                        r_next.st = ST_STANDBY;
                    else
                        r_next.result = 2'd2;
                end else if (r_reg.st != ST_STANDBY) begin
                    r_next.result = 2'd2;
                end else if (hwdata[2:0] != 3'b000) begin
                    r_next.result = 2'd2;
                end else if (opc == OP_UNLOCK) begin
                    r_next.latch = 1'b1;
                end else if (opc == OP_LOCK) begin
                    r_next.latch = 1'b0;
                end else if (opc == OP_SLEEP) begin
                    r_next.st = ST_DEEP;
                end else if (opc == OP_WRSTAT || (opc >= OP_PROG && opc <= OP_CHIP)) begin
                    if (!r_reg.latch) begin
                        r_next.result = 2'd2;
                    end else if (opc == OP_WRSTAT) begin
                        r_next.latch = 1'b0;
                        if (guard_pin_n) begin
                            r_next.bits = hwdata[BITS_LSB+16 +: 5];
                            r_next.comp = hwdata[COMP_POS+16];
                            r_next.lock = hwdata[LOCK_LSB+16 +: 2];
                        end else begin
                            r_next.result = 2'd2;
                        end
                    end else if (hit) begin
                        r_next.result = 2'd3;
                        r_next.latch  = 1'b0;
                    end else begin
                        r_next.awr  = 1'b1;
                        r_next.lo_q = t_lo;
                        r_next.hi_q = t_hi;
                        r_next.st   = ST_BUSY;
                        r_next.cnt  = 32'(OP_CYC);
                    end
                end else begin
                    r_next.result = 2'd2;
                end
            end
        end

        // address phase
        if (take) begin
            r_next.wr_ph  = hwrite;
            r_next.wr_off = haddr[7:0];
            r_next.rdata  = '0;
            if (!hwrite) begin
                if (haddr[7:0] == CTRL_OFF)
                    r_next.rdata = {24'h0, status};
                else if (haddr[7:0] == STATUS_OFF)
                    r_next.rdata = {20'h0, r_reg.st == ST_RECOVER,
                                    r_reg.st == ST_DEEP, r_reg.st != ST_STANDBY,
                                    r_reg.latch, status};
                else if (haddr[7:0] == ADDR_OFF)
                    r_next.rdata = {13'h0, r_reg.addr};
                else if (haddr[7:0] == RESULT_OFF)
                    r_next.rdata = {26'h0, r_reg.result, r_reg.last_op};
                else if (haddr[7:0] == RANGE_OFF)
                    r_next.rdata = {g.any, 5'h0, g.hi[18:12], 7'h0, g.lo[18:12], 5'h0};
                else
                    r_next.rdata = '0;
            end
        end
        // busy level registered together with the state
        r_next.busy_q = (r_next.st != ST_STANDBY);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg       <= '0;
            r_reg.st    <= ST_RECOVER;
            r_reg.bits  <= STATUS_RST[4:0];
            r_reg.strap <= 1'b1;
            r_reg.busy_q <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata      = r_reg.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign array_write = r_reg.awr;
    assign write_lo    = r_reg.lo_q;
    assign write_hi    = r_reg.hi_q;
    assign busy        = r_reg.busy_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_WRITE_NEEDS_LATCH: assert property (@(posedge clk) disable iff (!resetn)
        r_next.awr |-> r_reg.latch) else $error("write without latch");
    AST_NO_WRITE_DEEP: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.st == ST_DEEP |=> !r_reg.awr) else $error("write in deep power-down");
    AST_PIN_FREEZES: assert property (@(posedge clk) disable iff (!resetn)
        !guard_pin_n && $stable(guard_pin_n) |=> $stable(status)) else $error("guard bits changed");
    AST_NO_PROT_HIT: assert property (@(posedge clk) disable iff (!resetn)
        r_next.awr |-> !hit) else $error("protected range written");
    AST_BYTE_EDGE: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.wr_ph && r_reg.wr_off == CMD_OFF && hwdata[2:0] != 3'b000 |=> !r_reg.awr)
        else $error("ragged command accepted");
    AST_BUSY_ENDS: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.awr |-> ##[1:10] r_reg.st == ST_STANDBY) else $error("operation hung");
    AST_STANDBY_ONLY: assert property (@(posedge clk) disable iff (!resetn)
        r_next.awr |-> r_reg.st == ST_STANDBY) else $error("write while not standby");
    AST_ALL_COMP: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.comp && r_reg.bits[2:0] == 3'b000 |-> g.any && g.lo == '0 && g.hi == ARRAY_LAST)
        else $error("complement of none wrong");

    // ----------------------------------------
    // launch and latch checks
    // ----------------------------------------
    AST_PULSE_ONE: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.awr |=> !r_reg.awr) else $error("launch pulse too long");
    AST_LAUNCH_BUSY: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.awr |-> r_reg.st == ST_BUSY) else $error("launch without busy");
    AST_RANGE_ORDER: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.awr |-> r_reg.lo_q <= r_reg.hi_q) else $error("launch range reversed");
    AST_LATCH_DROPS: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.st == ST_BUSY && r_reg.cnt == '0 |=> !r_reg.latch)
        else $error("latch kept after operation");
    AST_LOCK_CMD: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.wr_ph && r_reg.wr_off == CMD_OFF && opc == OP_LOCK
        && r_reg.st == ST_STANDBY && hwdata[2:0] == 3'b000 |=> !r_reg.latch)
        else $error("lock command left latch set");

    // ----------------------------------------
    // power and state checks
    // ----------------------------------------
    AST_DEEP_WAKE: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.st == ST_DEEP && r_next.st != ST_DEEP
        |-> r_reg.wr_ph && r_reg.wr_off == CMD_OFF && opc == OP_WAKE)
        else $error("deep power-down left without wake");
    AST_SLEEP_ENTERS: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.wr_ph && r_reg.wr_off == CMD_OFF && opc == OP_SLEEP
        && r_reg.st == ST_STANDBY && hwdata[2:0] == 3'b000 |=> r_reg.st == ST_DEEP)
        else $error("sleep command not taken");
    AST_RECOVER_STAYS: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.st == ST_RECOVER && !r_reg.strap && r_reg.cnt != '0
        |=> r_reg.st == ST_RECOVER) else $error("recovery ended early");
    AST_NO_WRITE_RECOVER: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.st == ST_RECOVER |=> !r_reg.awr) else $error("write during recovery");
    AST_WRSTAT_PIN: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.wr_ph && r_reg.wr_off == CMD_OFF && !guard_pin_n |=> $stable(status))
        else $error("status written with guard pin low");

    // ----------------------------------------
    // guard decode checks and coverage
    // ----------------------------------------
    AST_FULL_CODE: assert property (@(posedge clk) disable iff (!resetn)
        !r_reg.comp && !r_reg.bits[4] && r_reg.bits[2]
        |-> g.any && g.lo == '0 && g.hi == ARRAY_LAST) else $error("full code wrong");
    AST_COMP_SIDE: assert property (@(posedge clk) disable iff (!resetn)
        r_reg.comp && g.any && g.lo != '0 |-> g.hi == ARRAY_LAST)
        else $error("complement range not one-sided");
    COV_RECOVER: cover property (@(posedge clk) r_reg.st == ST_RECOVER && r_reg.cnt != '0);
    COV_COMP_WRITE: cover property (@(posedge clk) r_reg.awr && r_reg.comp);
    COV_WRITE: cover property (@(posedge clk) r_reg.awr);
    COV_HIT: cover property (@(posedge clk) r_reg.result == 2'd3);
    COV_DEEP: cover property (@(posedge clk) r_reg.st == ST_DEEP);

endmodule

/* File: host_bus.sv */
// ahb-lite host model that issues flash commands as register writes
`timescale 1ns/10ps
module host_bus (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic      [31:0] rd_val,
    output logic      [15:0] rd_count,
    output logic             bus_hung
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, rd_val, rd_count, bus_hung} = '0;
        hsize = 3'b010;
    end

    // ----------------------------------------
    // one phase, held until hready at an edge
    // ----------------------------------------
    task hold();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 100) bus_hung <= 1'b1;
            @(posedge clk);
        end
    endtask

    // whole word command or read, never a partial unit
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hold();
        htrans <= 2'b00;
        hwdata <= d;
        hold();
        if (!wr) begin
            rd_val   <= hrdata;
            rd_count <= rd_count + 16'd1;
        end
    endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the flash write-protection block
`timescale 1ns/10ps
module testbench;
    import guard_pkg::*;
    logic        clk, resetn, hready, hsel, hwrite, hreadyout, hresp, guard_pin_n;
    logic        erase_cut_4k, erase_cut_64k, array_write, busy, bus_hung, cur_comp;
    logic [31:0] haddr, hwdata, hrdata, rd_val, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [18:0] write_lo, write_hi;
    logic [15:0] rd_count, rd_seen;
    logic [4:0]  cur_bits;
    logic [63:0] exp_r[$];
    logic [37:0] exp_w[$];
    int          err_count, checks_done, seed;
    op_t         op;

    assign hready = hreadyout;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    flash_write_protection u_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .guard_pin_n(guard_pin_n),
        .erase_cut_4k(erase_cut_4k), .erase_cut_64k(erase_cut_64k),
        .array_write(array_write), .write_lo(write_lo), .write_hi(write_hi), .busy(busy));
    host_bus u_host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_val(rd_val),
        .rd_count(rd_count), .bus_hung(bus_hung));

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task tally_and_finish();
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task want(input logic [37:0] g, input logic [37:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task timeout();
        err_count++;
        tally_and_finish();
    endtask
    always @(posedge bus_hung) timeout();

    // ----------------------------------------
    // result watcher: oldest note against output
    // ----------------------------------------
    always @(posedge clk) begin
        logic [63:0] e;
        if (rd_count !== rd_seen) begin
            rd_seen <= rd_count;
            e = exp_r.size() ? exp_r.pop_front() : '1;
            want(rd_val & e[63:32], e[31:0]);
        end
        if (array_write === 1'b1) want({write_lo, write_hi}, exp_w.size() ? exp_w.pop_front() : '1);
    end

    // ----------------------------------------
    // bus and command helpers
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        exp_r.push_back({m, v});
        u_host.xfer(1'b0, a, 32'h0);
    endtask
    task idle(input int lim);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0) begin
            n++;
            if (n > lim) timeout();
            @(posedge clk);
        end
        want(exp_w.size(), 0);
    endtask
    function automatic logic [31:0] cw(op_t o, logic [2:0] len, logic [4:0] b, logic c,
                                      logic [1:0] l);
        return {8'h00, l, c, b, 4'h0, o, 5'h00, len};
    endfunction
    function automatic logic [18:0] span(op_t o);
        return (o == OP_PROG) ? PAGE_SPAN : (o == OP_SECT) ? SECT_SPAN :
               (o == OP_BLK32) ? BLK32_SPAN : (o == OP_BLK64) ? BLK64_SPAN : ARRAY_LAST;
    endfunction
    // expected outcome from the guard field and complement bit
    function automatic logic [1:0] verdict(op_t o, logic [18:0] a);
        logic [18:0] lo, hi, sz, plo, phi;
        logic [2:0]  c;
        logic        all, none, hit;
        c    = cur_bits[2:0];
        lo   = a & ~span(o);
        hi   = lo | span(o);
        none = (c == 3'b000);
        all  = cur_bits[4] ? (c == 3'b111) : cur_bits[2];
        sz   = cur_bits[4] ? (c[2] ? 19'h08000 : 19'h01000 << (c - 3'd1))
                           : 19'h10000 << (c - 3'd1);
        plo  = cur_bits[3] ? 19'h0 : ARRAY_LAST - sz + 19'h1;
        phi  = cur_bits[3] ? sz - 19'h1 : ARRAY_LAST;
        if (!cur_comp) hit = all | (!none & lo <= phi & hi >= plo);
        else hit = none | (!all & !(lo >= plo & hi <= phi));
        return hit ? 2'd3 : 2'd0;
    endfunction
    // res 0 = accepted (launched for PROG to CHIP), 2 = refused, 3 = protected
    task run(input op_t o, input logic [18:0] a, input logic [2:0] len, input logic [1:0] res);
        if (res == 2'd0 && o >= OP_PROG && o <= OP_CHIP) begin
            exp_w.push_back({a & ~span(o), a | span(o)});
        end
        wr(ADDR_OFF, {13'h0, a});
        wr(CMD_OFF, cw(o, len, cur_bits, cur_comp, 2'b00));
        idle(50);
        rd(RESULT_OFF, res ? 32'h30 : 32'h0f, res ? {26'h0, res, 4'h0} : {28'h0, o});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {resetn, erase_cut_4k, erase_cut_64k, cur_bits, cur_comp, rd_seen} = '0;
        {err_count, checks_done} = '0;
        guard_pin_n = 1'b1;
        seed = 32'hc6f9bf93;
        repeat (12) @(posedge clk);
        want(busy, 1'b1);
        resetn <= 1'b1;
        repeat (10000) @(posedge clk);
        rd(CTRL_OFF, 32'hff, STATUS_RST);
        rd(STATUS_OFF, 32'hfff, 32'h0);
        rd(8'h18, 32'hffffffff, 32'h0);
        run(OP_PROG, 19'h00100, 3'h0, 2'd2);
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        run(OP_PROG, 19'h00100, 3'h3, 2'd2);
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        run(OP_LOCK, 19'h0, 3'h0, 2'd0);
        run(OP_PROG, 19'h00100, 3'h0, 2'd2);
        for (int k = 0; k < 64; k++) begin
            {cur_comp, cur_bits} = 6'(k);
            run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
            run(OP_WRSTAT, 19'h0, 3'h0, 2'd0);
            rd(CTRL_OFF, 32'h3f, {26'h0, cur_comp, cur_bits});
            for (int j = 0; j < 5; j++) begin
                op = op_t'(4 + j);
                r  = $random(seed);
                run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
                run(op, r[20] ? r[18:0] : {{3{r[19]}}, r[15:0]}, 3'h0,
                    verdict(op, r[20] ? r[18:0] : {{3{r[19]}}, r[15:0]}));
            end
        end
        {cur_comp, cur_bits} = 6'h01;
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        run(OP_WRSTAT, 19'h0, 3'h0, 2'd0);
        rd(RANGE_OFF, 32'hffffffff, 32'h83f80e00);
        guard_pin_n <= 1'b0;
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        wr(CMD_OFF, cw(OP_WRSTAT, 3'h0, 5'h1f, 1'b0, 2'b11));
        idle(50);
        rd(CTRL_OFF, 32'hdf, 32'h01);
        guard_pin_n <= 1'b1;
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        wr(CMD_OFF, cw(OP_SLEEP, 3'h0, 5'h0, 1'b0, 2'b00));
        repeat (3) @(posedge clk);
        rd(STATUS_OFF, 32'h400, 32'h400);
        wr(CMD_OFF, cw(OP_PROG, 3'h0, 5'h0, 1'b0, 2'b00));
        repeat (3) @(posedge clk);
        rd(RESULT_OFF, 32'h30, 32'h20);
        wr(CMD_OFF, cw(OP_WAKE, 3'h0, 5'h0, 1'b0, 2'b00));
        idle(500);
        run(OP_UNLOCK, 19'h0, 3'h0, 2'd0);
        run(OP_PROG, 19'h3ff00, 3'h0, 2'd0);
        resetn       <= 1'b0;
        erase_cut_4k <= 1'b1;
        repeat (12) @(posedge clk);
        want(busy, 1'b1);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        wr(CMD_OFF, cw(OP_UNLOCK, 3'h0, 5'h0, 1'b0, 2'b00));
        rd(RESULT_OFF, 32'h30, 32'h20);
        repeat (44000) @(posedge clk);
        want(busy, 1'b1);
        idle(2000);
        erase_cut_4k <= 1'b0;
        tally_and_finish();
    end
endmodule
